// ==== pkg/cca_pkg.sv ====
// Purpose: shared constants for the counter array register block
// Assumes: 8-bit special function register bus, one system clock
// Notes:   offsets are byte addresses on that bus
package cca_pkg;

   localparam int NUM_MOD = 6;

   // special function register addresses
   localparam logic [7:0] ADDR_CTRL      = 8'hd8;
   localparam logic [7:0] ADDR_MODE      = 8'hd9;
   localparam logic [7:0] ADDR_PWM_CFG   = 8'hdf;
   localparam logic [7:0] ADDR_CNT_LO    = 8'hf9;
   localparam logic [7:0] ADDR_CNT_HI    = 8'hfa;
   localparam logic [NUM_MOD-1:0][7:0] ADDR_CPM = '{8'hce, 8'hde, 8'hdd, 8'hdc, 8'hdb, 8'hda};
   localparam logic [NUM_MOD-1:0][7:0] ADDR_VLO = '{8'hd2, 8'hfd, 8'hed, 8'heb, 8'he9, 8'hfb};
   localparam logic [NUM_MOD-1:0][7:0] ADDR_VHI = '{8'hd3, 8'hfe, 8'hee, 8'hec, 8'hea, 8'hfc};

   // control register fields
   localparam int CTL_WRAP = 7;
   localparam int CTL_RUN  = 6;
   // mode register fields
   localparam int MD_IDLE  = 7;
   localparam int MD_WATCHDOG_ENABLE_BIT  = 6;
   localparam int MD_WDLCK = 5;
   localparam int MD_CPS   = 1;
   localparam int MD_ECF   = 0;
   // pwm config register fields
   localparam int PC_RELOAD_VIEW_SELECT = 7;
   localparam int PC_ECOV  = 6;
   localparam int PC_COVF  = 5;
   // module mode register fields
   localparam int CM_WIDE  = 7;
   localparam int CM_ECOM  = 6;
   localparam int CM_CAPP  = 5;
   localparam int CM_CAPN  = 4;
   localparam int CM_MAT   = 3;
   localparam int CM_TOG   = 2;
   localparam int CM_PWM   = 1;
   localparam int CM_ECCF  = 0;

   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic       RST_WATCHDOG_ENABLE_BIT = 1'b1;

   // timebase selection
   localparam logic [2:0] CPS_DIV12 = 3'h0;
   localparam logic [2:0] CPS_DIV4  = 3'h1;
   localparam logic [2:0] CPS_EXT   = 3'h3;
   localparam logic [2:0] CPS_SYS   = 3'h4;
   localparam logic [3:0] DIV12_LAST = 4'hb;
   localparam logic [3:0] DIV4_LAST  = 4'h3;

   // cycle length mask for 8 to 11 bit pwm
   function automatic logic [10:0] cyc_mask(input logic [1:0] clsel);
      cyc_mask = 11'h7ff >> (2'd3 - clsel);
   endfunction : cyc_mask

endpackage : cca_pkg

// ==== src/cca_channel.sv ====
// Purpose: one capture/compare module of the counter array
// Assumes: pin_sync_in already passed two flip-flops
// Notes:   value storage lives in the top; this holds edge and pin state
`timescale 1ns/1ps
module cca_channel (
   input  wire logic        clk_in,       // system clock
   input  wire logic        rst_in,       // sync reset, active high
   input  wire logic        tick_in,      // counter advance enable
   input  wire logic [15:0] cnt_in,       // live count
   input  wire logic [7:0]  mode_in,      // module mode register
   input  wire logic [15:0] val_in,       // compare value
   input  wire logic [1:0]  clsel_in,     // short pwm cycle length
   input  wire logic        pin_sync_in,  // synchronised capture input
   output logic             match_out,    // compare match pulse
   output logic             capture_out,  // capture edge pulse
   output logic             pin_out       // module output pin
);

   typedef struct packed {
      logic pin_q;
      logic out;
   } cca_ch_t;

   cca_ch_t     r_r;
   cca_ch_t     r_nxt;
   logic [10:0] msk;
   logic        short_pwm;
   logic        hit;
   logic        hit8;
   logic        ge;

   always_comb begin
      msk       = cca_pkg::cyc_mask(clsel_in);
      short_pwm = mode_in[cca_pkg::CM_PWM] & ~mode_in[cca_pkg::CM_WIDE];
      hit8      = cnt_in[7:0] == val_in[7:0];
      hit       = short_pwm ? ((cnt_in[10:0] & msk) == (val_in[10:0] & msk))
                            : (cnt_in == val_in);
      ge        = short_pwm ? ((cnt_in[10:0] & msk) >= (val_in[10:0] & msk))
                            : (cnt_in >= val_in);
      match_out   = tick_in & mode_in[cca_pkg::CM_ECOM] & hit;
      capture_out = (mode_in[cca_pkg::CM_CAPP] & pin_sync_in & ~r_r.pin_q) |
                    (mode_in[cca_pkg::CM_CAPN] & ~pin_sync_in & r_r.pin_q);
      r_nxt       = r_r;
      r_nxt.pin_q = pin_sync_in;
      if (mode_in[cca_pkg::CM_PWM] && mode_in[cca_pkg::CM_TOG]) begin
         // frequency output: toggle on low byte match
         if (tick_in && mode_in[cca_pkg::CM_ECOM] && hit8) begin
            r_nxt.out = ~r_r.out;
         end
      end else if (mode_in[cca_pkg::CM_PWM]) begin
         r_nxt.out = mode_in[cca_pkg::CM_ECOM] & ge;
      end else if (mode_in[cca_pkg::CM_TOG] && match_out) begin
         r_nxt.out = ~r_r.out;
      end
      pin_out = r_r.out;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

endmodule : cca_channel

// ==== src/cca_top.sv ====
// Purpose: counter array with six capture/compare modules and sfr access
// Assumes: one-cycle read and write strobes from the processor sfr bus
// Notes:   read data appears the cycle after the read strobe
// Overview of operation
// - wide select gives 16-bit pwm, else short
// - pwm plus toggle gives frequency output
// - flag interrupt mask gates module flag request
// - watchdog on: module 5 mode writes ignored
// - watchdog on: counter byte writes ignored
// - high byte reads snapshot taken at low read
// - 16-bit counter, two byte registers, reset zero
// - six modules each hold 16-bit value
// - reload view select picks reload or value
// - value low write clears comparator enable
// - value high write sets comparator enable
// - counter rollover sets sticky wrap flag
// - match with MAT set, or capture, sets sticky module flag
// - comparator enable turns on module comparator
`timescale 1ns/1ps
module cca_top (
   input  wire logic       CLOCK_IN,                  // 25 MHz system clock
   input  wire logic       RST_IN,                    // sync reset, active high
   input  wire logic [7:0] SFR_ADDR_IN,               // register address
   input  wire logic       SFR_WR_IN,                 // write strobe
   input  wire logic       SFR_RD_IN,                 // read strobe
   input  wire logic [7:0] SFR_WDATA_IN,              // write data
   input  wire logic       EXT_CLK_IN,                // external count input pin
   input  wire logic [5:0] CAPTURE_PIN_IN,            // capture input pins
   output logic      [7:0] SFR_RDATA_OUT,             // read data
   output logic      [5:0] MODULE_OUTPUT_PIN_OUT,     // module output pins
   output logic            IRQ_OUT,                   // combined interrupt request
   output logic            WDT_RESET_OUT              // watchdog timeout pulse
);

   localparam int NM = cca_pkg::NUM_MOD;
   localparam logic [2:0] NONE = 3'h7;

   typedef struct packed {
      logic [15:0]        cnt;
      logic [7:0]         snap;
      logic               wrap;
      logic               run;
      logic [NM-1:0]      ccf;
      logic               idle;
      logic               watchdog_enable_bit;
      logic               wdlck;
      logic [2:0]         cps;
      logic               ecf;
      logic               reload_view_select;
      logic               ecov;
      logic               covf;
      logic [1:0]         clsel;
      logic [NM-1:0][7:0] mode;
      logic [NM-1:0][15:0] val;
      logic [NM-1:0][15:0] rld;
      logic [3:0]         div;
      logic [1:0]         ext_s;
      logic               ext_q;
      logic [NM-1:0]      cap_s1;
      logic [NM-1:0]      cap_s2;
      logic [7:0]         rdata;
      logic               irq;
      logic               wdt;
   } cca_state_t;

   cca_state_t    r_r;
   cca_state_t    r_nxt;
   logic          tick;
   logic [10:0]   msk;
   logic          cyc_ovf;
   logic [NM-1:0] match;
   logic [NM-1:0] capture;
   logic [NM-1:0] pin;
   logic [2:0]    lo_i;
   logic [2:0]    hi_i;
   logic [2:0]    cpm_i;

   // module index for an address in a table, NONE when absent
   function automatic logic [2:0] find_idx(input logic [7:0] a,
                                           input logic [NM-1:0][7:0] tab);
      find_idx = NONE;
      for (int k = 0; k < NM; k++) begin
         if (a == tab[k]) begin
            find_idx = 3'(k);
         end
      end
   endfunction : find_idx

   genvar g;
   generate
      for (g = 0; g < NM; g++) begin : g_ch
         cca_channel u_ch (
            .clk_in      (CLOCK_IN),
            .rst_in      (RST_IN),
            .tick_in     (tick),
            .cnt_in      (r_r.cnt),
            .mode_in     (r_r.mode[g]),
            .val_in      (r_r.val[g]),
            .clsel_in    (r_r.clsel),
            .pin_sync_in (r_r.cap_s2[g]),
            .match_out   (match[g]),
            .capture_out (capture[g]),
            .pin_out     (pin[g])
         );
      end
   endgenerate

   // timebase enable
   always_comb begin
      tick = 1'b0;
      if (r_r.run) begin
         if (r_r.cps == cca_pkg::CPS_DIV12) begin
            tick = r_r.div == cca_pkg::DIV12_LAST;
         end else if (r_r.cps == cca_pkg::CPS_DIV4) begin
            tick = r_r.div[1:0] == cca_pkg::DIV4_LAST[1:0];
         end else if (r_r.cps == cca_pkg::CPS_SYS) begin
            tick = 1'b1;
         end else if (r_r.cps == cca_pkg::CPS_EXT) begin
            tick = r_r.ext_q & ~r_r.ext_s[1];
         end
      end
      msk     = cca_pkg::cyc_mask(r_r.clsel);
      cyc_ovf = tick && ((r_r.cnt[10:0] & msk) == msk);
      lo_i    = find_idx(SFR_ADDR_IN, cca_pkg::ADDR_VLO);
      hi_i    = find_idx(SFR_ADDR_IN, cca_pkg::ADDR_VHI);
      cpm_i   = find_idx(SFR_ADDR_IN, cca_pkg::ADDR_CPM);
   end

   always_comb begin
      r_nxt        = r_r;
      r_nxt.ext_s  = {r_r.ext_s[0], EXT_CLK_IN};
      r_nxt.ext_q  = r_r.ext_s[1];
      r_nxt.cap_s1 = CAPTURE_PIN_IN;
      r_nxt.cap_s2 = r_r.cap_s1;
      r_nxt.wdt    = 1'b0;
      r_nxt.div    = (r_r.div == cca_pkg::DIV12_LAST) ? 4'h0 : r_r.div + 4'h1;

      // counting, wrap and cycle overflow
      if (tick) begin
         r_nxt.cnt = r_r.cnt + 16'h0001;
         if (r_r.cnt == 16'hffff) begin
            r_nxt.wrap = 1'b1;
         end
      end
      if (cyc_ovf) begin
         r_nxt.covf = 1'b1;
      end
      if (r_r.watchdog_enable_bit && tick && r_r.cnt[7:0] == 8'hff && r_r.cnt[15:8] == r_r.val[5][15:8]) begin
         r_nxt.wdt = 1'b1;
      end

      // software writes; flags set below so a same-cycle event wins
      if (SFR_WR_IN) begin
         if (SFR_ADDR_IN == cca_pkg::ADDR_CTRL) begin
            r_nxt.wrap = SFR_WDATA_IN[cca_pkg::CTL_WRAP];
            r_nxt.run  = SFR_WDATA_IN[cca_pkg::CTL_RUN];
            r_nxt.ccf  = SFR_WDATA_IN[NM-1:0];
         end else if (SFR_ADDR_IN == cca_pkg::ADDR_MODE) begin
            if (!r_r.watchdog_enable_bit) begin
               r_nxt.idle = SFR_WDATA_IN[cca_pkg::MD_IDLE];
               r_nxt.cps  = SFR_WDATA_IN[cca_pkg::MD_CPS +: 3];
            end
            r_nxt.watchdog_enable_bit  = SFR_WDATA_IN[cca_pkg::MD_WATCHDOG_ENABLE_BIT] | r_r.wdlck;
            r_nxt.wdlck = SFR_WDATA_IN[cca_pkg::MD_WDLCK] | r_r.wdlck;
            if (SFR_WDATA_IN[cca_pkg::MD_WDLCK]) begin
               r_nxt.watchdog_enable_bit = 1'b1;
            end
            r_nxt.ecf = SFR_WDATA_IN[cca_pkg::MD_ECF];
         end else if (SFR_ADDR_IN == cca_pkg::ADDR_PWM_CFG) begin
            r_nxt.reload_view_select = SFR_WDATA_IN[cca_pkg::PC_RELOAD_VIEW_SELECT];
            r_nxt.ecov  = SFR_WDATA_IN[cca_pkg::PC_ECOV];
            r_nxt.covf  = SFR_WDATA_IN[cca_pkg::PC_COVF] | cyc_ovf;
            r_nxt.clsel = SFR_WDATA_IN[1:0];
         end else if (SFR_ADDR_IN == cca_pkg::ADDR_CNT_LO) begin
            if (!r_r.watchdog_enable_bit) begin
               r_nxt.cnt[7:0] = SFR_WDATA_IN;
            end
         end else if (SFR_ADDR_IN == cca_pkg::ADDR_CNT_HI) begin
            if (!r_r.watchdog_enable_bit) begin
               r_nxt.cnt[15:8] = SFR_WDATA_IN;
            end
         end else if (cpm_i != NONE) begin
            if (!(cpm_i == 3'h5 && r_r.watchdog_enable_bit)) begin
               r_nxt.mode[cpm_i] = SFR_WDATA_IN;
            end
         end else if (lo_i != NONE) begin
            if (r_r.reload_view_select) begin
               r_nxt.rld[lo_i][7:0] = SFR_WDATA_IN;
            end else begin
               r_nxt.val[lo_i][7:0] = SFR_WDATA_IN;
            end
            if (!(lo_i == 3'h5 && r_r.watchdog_enable_bit)) begin
               r_nxt.mode[lo_i][cca_pkg::CM_ECOM] = 1'b0;
            end
         end else if (hi_i != NONE) begin
            if (hi_i == 3'h5 && r_r.watchdog_enable_bit) begin
               // watchdog refresh: next timeout offset from the live count
               r_nxt.val[5][15:8] = r_r.cnt[15:8] + r_r.val[5][7:0];
            end else if (r_r.reload_view_select) begin
               r_nxt.rld[hi_i][15:8] = SFR_WDATA_IN;
            end else begin
               r_nxt.val[hi_i][15:8] = SFR_WDATA_IN;
            end
            if (!(hi_i == 3'h5 && r_r.watchdog_enable_bit)) begin
               r_nxt.mode[hi_i][cca_pkg::CM_ECOM] = 1'b1;
            end
         end
      end

      // module events
      for (int k = 0; k < NM; k++) begin
         if (r_r.mode[k][cca_pkg::CM_PWM] && !r_r.mode[k][cca_pkg::CM_WIDE] && cyc_ovf &&
             r_r.clsel != 2'h0) begin
            r_nxt.val[k][10:0] = r_r.rld[k][10:0];
         end
         if (capture[k]) begin
            r_nxt.val[k] = r_r.cnt;
         end
         if (capture[k] || (match[k] && r_r.mode[k][cca_pkg::CM_MAT])) begin
            r_nxt.ccf[k] = 1'b1;
         end
      end
      if (tick && r_r.cnt == 16'hffff) begin
         r_nxt.wrap = 1'b1;
      end

      // read path; low byte read takes the high byte snapshot
      r_nxt.rdata = cca_pkg::RST_BYTE;
      if (SFR_RD_IN) begin
         if (SFR_ADDR_IN == cca_pkg::ADDR_CTRL) begin
            r_nxt.rdata = {r_r.wrap, r_r.run, r_r.ccf};
         end else if (SFR_ADDR_IN == cca_pkg::ADDR_MODE) begin
            r_nxt.rdata = {r_r.idle, r_r.watchdog_enable_bit, r_r.wdlck, 1'b0, r_r.cps, r_r.ecf};
         end else if (SFR_ADDR_IN == cca_pkg::ADDR_PWM_CFG) begin
            r_nxt.rdata = {r_r.reload_view_select, r_r.ecov, r_r.covf, 3'h0, r_r.clsel};
         end else if (SFR_ADDR_IN == cca_pkg::ADDR_CNT_LO) begin
            r_nxt.rdata = r_r.cnt[7:0];
            r_nxt.snap  = r_r.cnt[15:8];
         end else if (SFR_ADDR_IN == cca_pkg::ADDR_CNT_HI) begin
            r_nxt.rdata = r_r.snap;
         end else if (cpm_i != NONE) begin
            r_nxt.rdata = r_r.mode[cpm_i];
         end else if (lo_i != NONE) begin
            r_nxt.rdata = r_r.reload_view_select ? r_r.rld[lo_i][7:0] : r_r.val[lo_i][7:0];
         end else if (hi_i != NONE) begin
            r_nxt.rdata = r_r.reload_view_select ? r_r.rld[hi_i][15:8] : r_r.val[hi_i][15:8];
         end
      end

      // interrupt request from masked flags
      r_nxt.irq = (r_r.wrap & r_r.ecf) | (r_r.covf & r_r.ecov);
      for (int k = 0; k < NM; k++) begin
         if (r_r.ccf[k] && r_r.mode[k][cca_pkg::CM_ECCF]) begin
            r_nxt.irq = 1'b1;
         end
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         r_r      <= '0;
         r_r.watchdog_enable_bit <= cca_pkg::RST_WATCHDOG_ENABLE_BIT;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign SFR_RDATA_OUT         = r_r.rdata;
   assign IRQ_OUT               = r_r.irq;
   assign WDT_RESET_OUT         = r_r.wdt;
   assign MODULE_OUTPUT_PIN_OUT = pin;

endmodule : cca_top

// ==== verification/cca_top_assertions.sv ====
// Purpose: port-level checks for the counter array register block
// Assumes: one-cycle strobes, read data one cycle after the read strobe
// Notes:   watchdog and run state shadowed from bus writes
`timescale 1ns/1ps
module cca_top_chk (
   input  wire logic       CLOCK_IN,               // system clock
   input  wire logic       RST_IN,                 // sync reset
   input  wire logic [7:0] SFR_ADDR_IN,            // address
   input  wire logic       SFR_WR_IN,              // write strobe
   input  wire logic       SFR_RD_IN,              // read strobe
   input  wire logic [7:0] SFR_WDATA_IN,           // write data
   input  wire logic [7:0] SFR_RDATA_OUT,          // read data
   input  wire logic [5:0] MODULE_OUTPUT_PIN_OUT,  // module pins
   input  wire logic       IRQ_OUT,                // interrupt
   input  wire logic       WDT_RESET_OUT           // timeout pulse
);
   logic wd_r;
   logic lock_r;
   logic run_r;
   wire logic md_w  = SFR_WR_IN && SFR_ADDR_IN == cca_pkg::ADDR_MODE;
   wire logic ro    = SFR_RD_IN && !SFR_WR_IN;
   wire logic rd_hi = ro && SFR_ADDR_IN == cca_pkg::ADDR_CNT_HI;
   wire logic rd_lo = ro && SFR_ADDR_IN == cca_pkg::ADDR_CNT_LO;
   wire logic rd_v1 = ro && SFR_ADDR_IN == cca_pkg::ADDR_VLO[1];
   wire logic rd_m1 = ro && SFR_ADDR_IN == cca_pkg::ADDR_CPM[1];
   wire logic rd_m5 = ro && SFR_ADDR_IN == cca_pkg::ADDR_CPM[5];
   wire logic wr_l1 = SFR_WR_IN && SFR_ADDR_IN == cca_pkg::ADDR_VLO[1];
   wire logic wr_h1 = SFR_WR_IN && SFR_ADDR_IN == cca_pkg::ADDR_VHI[1];
   wire logic wr_m5 = SFR_WR_IN && SFR_RD_IN && wd_r && SFR_ADDR_IN == cca_pkg::ADDR_CPM[5];
   wire logic wr_lo = SFR_WR_IN && SFR_RD_IN && wd_r && !run_r
                      && SFR_ADDR_IN == cca_pkg::ADDR_CNT_LO;
   wire logic lk_in = SFR_WDATA_IN[cca_pkg::MD_WDLCK];

   // shadow of watchdog enable and run bit
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         wd_r   <= cca_pkg::RST_WATCHDOG_ENABLE_BIT;
         lock_r <= 1'b0;
         run_r  <= 1'b0;
      end else begin
         if (md_w) begin
            wd_r   <= SFR_WDATA_IN[cca_pkg::MD_WATCHDOG_ENABLE_BIT] | lk_in | lock_r;
            lock_r <= lock_r | lk_in;
         end
         if (SFR_WR_IN && SFR_ADDR_IN == cca_pkg::ADDR_CTRL) begin
            run_r <= SFR_WDATA_IN[cca_pkg::CTL_RUN];
         end
      end
   end

   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (RST_IN);

   a_read_idle_zero: assert property (!SFR_RD_IN |=> SFR_RDATA_OUT == 8'h00)
      else $error("read data not cleared");
   a_reset_quiet: assert property ($fell(RST_IN) |-> SFR_RDATA_OUT == 8'h00 && !IRQ_OUT
      && !WDT_RESET_OUT && MODULE_OUTPUT_PIN_OUT == 6'h00) else $error("outputs not reset");
   a_wdt_one_pulse: assert property (WDT_RESET_OUT |=> !WDT_RESET_OUT)
      else $error("timeout pulse too long");
   a_snap_hold: assert property (rd_hi ##1 rd_hi |=> $stable(SFR_RDATA_OUT))
      else $error("snapshot changed without low read");
   a_value_back: assert property (wr_l1 ##1 rd_v1 |=> SFR_RDATA_OUT == $past(SFR_WDATA_IN, 2))
      else $error("value byte not stored");
   a_mode5_locked: assert property (wr_m5 ##1 rd_m5 |=> $stable(SFR_RDATA_OUT))
      else $error("module 5 mode written while guarded");
   a_count_locked: assert property (wr_lo ##1 rd_lo |=> $stable(SFR_RDATA_OUT))
      else $error("count written while guarded");
   a_low_clr_ecom: assert property (wr_l1 ##1 rd_m1 |=> !SFR_RDATA_OUT[cca_pkg::CM_ECOM])
      else $error("comparator enable not cleared");
   a_high_set_ecom: assert property (wr_h1 ##1 rd_m1 |=> SFR_RDATA_OUT[cca_pkg::CM_ECOM])
      else $error("comparator enable not set");
endmodule : cca_top_chk

bind cca_top cca_top_chk u_chk (
   .CLOCK_IN, .RST_IN, .SFR_ADDR_IN, .SFR_WR_IN, .SFR_RD_IN, .SFR_WDATA_IN,
   .SFR_RDATA_OUT, .MODULE_OUTPUT_PIN_OUT, .IRQ_OUT, .WDT_RESET_OUT
);

// ==== verification/testbench.sv ====
// Purpose: self-checking bench for the counter array register block
// Assumes: read data one cycle after the read strobe
// Notes:   expectations queued at issue, compared by a monitor
`timescale 1ns/1ps
module testbench;
   logic        clk, rst, wr, rd, ext, irq, wdto, rd_pend;
   logic [7:0]  addr, wdata, rdata, d0, d1;
   logic [5:0]  cap, pins, p;
   logic [23:0] ent;
   logic [23:0] q_exp[$];
   integer      seed, n_mismatch, n_checks, i, k;

   cca_top dut (
      .CLOCK_IN(clk), .RST_IN(rst), .SFR_ADDR_IN(addr), .SFR_WR_IN(wr), .SFR_RD_IN(rd),
      .SFR_WDATA_IN(wdata), .EXT_CLK_IN(ext), .CAPTURE_PIN_IN(cap), .SFR_RDATA_OUT(rdata),
      .MODULE_OUTPUT_PIN_OUT(pins), .IRQ_OUT(irq), .WDT_RESET_OUT(wdto));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one bus cycle; a read notes {addr, mask, expected}
   task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
                      input logic [7:0] m, input logic [7:0] e);
      @(posedge clk);
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= d;
      if (r) q_exp.push_back({a, m, e & m});
   endtask : bus

   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, 1'b0, a, d, 8'h00, 8'h00);
   endtask : wr8

   task automatic rd8(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, 1'b1, a, 8'h00, 8'hff, e);
   endtask : rd8

   task automatic idle(input integer n);
      repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00);
   endtask : idle

   task automatic end_of_test;
      if (q_exp.size() != 0) begin
         n_mismatch++;
         $display("ERROR read queue expected 0 seen %0d", q_exp.size());
      end
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test

   // capture and count pins get noise; module 3 captures from it late in the run
   always @(posedge clk) begin
      cap <= $random(seed);
      ext <= $random(seed);
   end

   always @(posedge clk) begin
      if (rd_pend) begin
         ent = q_exp.pop_front();
         check($sformatf("read %h", ent[23:16]), rdata & ent[15:8], ent[7:0]);
      end
      rd_pend <= rd;
   end

   initial begin
      seed = 59308;
      {rst, wr, rd, rd_pend} = 4'h8;
      {addr, wdata} = 16'h0;
      n_mismatch = 0;
      n_checks = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (k = 0; k < 6; k++) begin
         rd8(cca_pkg::ADDR_VLO[k], 8'h00);
         rd8(cca_pkg::ADDR_VHI[k], 8'h00);
      end
      rd8(8'h00, 8'h00);
      rd8(cca_pkg::ADDR_MODE, 8'h40);
      bus(1'b1, 1'b1, cca_pkg::ADDR_CPM[5], 8'h42, 8'hff, 8'h00);
      rd8(cca_pkg::ADDR_CPM[5], 8'h00);
      bus(1'b1, 1'b1, cca_pkg::ADDR_CNT_LO, 8'h5a, 8'hff, 8'h00);
      rd8(cca_pkg::ADDR_CNT_LO, 8'h00);
      wr8(cca_pkg::ADDR_CNT_HI, 8'ha5);
      rd8(cca_pkg::ADDR_CNT_LO, 8'h00);
      rd8(cca_pkg::ADDR_CNT_HI, 8'h00);
      rd8(cca_pkg::ADDR_CNT_HI, 8'h00);
      wr8(cca_pkg::ADDR_MODE, 8'h00);
      for (k = 0; k < 6; k++) begin
         d0 = $random(seed);
         d1 = $random(seed);
         wr8(cca_pkg::ADDR_VLO[k], d0);
         rd8(cca_pkg::ADDR_VLO[k], d0);
         wr8(cca_pkg::ADDR_VHI[k], d1);
         rd8(cca_pkg::ADDR_CPM[k], 8'h40);
         rd8(cca_pkg::ADDR_VHI[k], d1);
         wr8(cca_pkg::ADDR_VLO[k], d0);
         rd8(cca_pkg::ADDR_CPM[k], 8'h00);
      end
      // reload view on module 5
      wr8(cca_pkg::ADDR_PWM_CFG, 8'h80);
      rd8(cca_pkg::ADDR_VLO[5], 8'h00);
      wr8(cca_pkg::ADDR_VLO[5], 8'h3c);
      rd8(cca_pkg::ADDR_VLO[5], 8'h3c);
      wr8(cca_pkg::ADDR_PWM_CFG, 8'h00);
      rd8(cca_pkg::ADDR_VLO[5], d0);
      // count through the wrap with wrap interrupt on
      wr8(cca_pkg::ADDR_CNT_LO, 8'hf0);
      wr8(cca_pkg::ADDR_CNT_HI, 8'hff);
      rd8(cca_pkg::ADDR_CNT_LO, 8'hf0);
      rd8(cca_pkg::ADDR_CNT_HI, 8'hff);
      wr8(cca_pkg::ADDR_MODE, 8'h09);
      wr8(cca_pkg::ADDR_CTRL, 8'h40);
      idle(40);
      rd8(cca_pkg::ADDR_CNT_HI, 8'hff);
      bus(1'b0, 1'b1, cca_pkg::ADDR_CNT_LO, 8'h00, 8'h00, 8'h00);
      rd8(cca_pkg::ADDR_CNT_HI, 8'h00);
      wr8(cca_pkg::ADDR_MODE, 8'h05);
      rd8(cca_pkg::ADDR_CTRL, 8'hc0);
      check("irq wrap", {7'h0, irq}, 8'h01);
      wr8(cca_pkg::ADDR_MODE, 8'h04);
      idle(2);
      @(negedge clk);
      check("irq masked", {7'h0, irq}, 8'h00);
      wr8(cca_pkg::ADDR_CTRL, 8'h00);
      rd8(cca_pkg::ADDR_CTRL, 8'h00);
      // match on module 0
      wr8(cca_pkg::ADDR_VLO[0], 8'h30);
      wr8(cca_pkg::ADDR_VHI[0], 8'h00);
      wr8(cca_pkg::ADDR_CPM[0], 8'h49);
      wr8(cca_pkg::ADDR_CNT_LO, 8'h00);
      wr8(cca_pkg::ADDR_MODE, 8'h08);
      wr8(cca_pkg::ADDR_CTRL, 8'h40);
      idle(60);
      wr8(cca_pkg::ADDR_MODE, 8'h04);
      bus(1'b0, 1'b1, cca_pkg::ADDR_CTRL, 8'h00, 8'h01, 8'h01);
      check("irq match", {7'h0, irq}, 8'h01);
      wr8(cca_pkg::ADDR_CPM[0], 8'h48);
      idle(2);
      @(negedge clk);
      check("irq flag masked", {7'h0, irq}, 8'h00);
      bus(1'b0, 1'b1, cca_pkg::ADDR_CTRL, 8'h00, 8'h01, 8'h01);
      wr8(cca_pkg::ADDR_CTRL, 8'h00);
      // pwm modes on module 2, count from 0x0040
      wr8(cca_pkg::ADDR_VLO[2], 8'h00);
      wr8(cca_pkg::ADDR_VHI[2], 8'h80);
      wr8(cca_pkg::ADDR_CPM[2], 8'hc2);
      wr8(cca_pkg::ADDR_CNT_LO, 8'h40);
      wr8(cca_pkg::ADDR_MODE, 8'h08);
      wr8(cca_pkg::ADDR_CTRL, 8'h40);
      idle(4);
      check("wide pwm pin", {7'h0, pins[2]}, 8'h00);
      wr8(cca_pkg::ADDR_CPM[2], 8'h42);
      idle(4);
      check("short pwm pin", {7'h0, pins[2]}, 8'h01);
      wr8(cca_pkg::ADDR_CPM[2], 8'h46);
      idle(2);
      p = pins;
      for (i = 0; i < 600 && pins[2] === p[2]; i++) idle(1);
      check("freq output", {7'h0, pins[2] !== p[2]}, 8'h01);
      // positive edge capture on module 3 from the pin noise
      wr8(cca_pkg::ADDR_CPM[3], 8'h20);
      idle(40);
      bus(1'b0, 1'b1, cca_pkg::ADDR_CTRL, 8'h00, 8'h08, 8'h08);
      // watchdog: count 0x01f0, timeout at 0x01ff with module 5 high 0x01
      wr8(cca_pkg::ADDR_MODE, 8'h04);
      wr8(cca_pkg::ADDR_VHI[5], 8'h01);
      wr8(cca_pkg::ADDR_CNT_LO, 8'hf0);
      wr8(cca_pkg::ADDR_CNT_HI, 8'h01);
      wr8(cca_pkg::ADDR_MODE, 8'h48);
      for (i = 0; i < 40 && wdto !== 1'b1; i++) idle(1);
      check("watchdog pulse", {7'h0, wdto}, 8'h01);
      check("watchdog delay", i[7:0], 8'h12);
      idle(3);
      end_of_test();
   end
endmodule : testbench
